/* File: lc_defs.svh */
// Register offsets, field positions, reset values and timing counts of the in-band loop code block.
// Assumes inclusion by bare name from every file that needs these constants.
`ifndef LC_DEFS_SVH
`define LC_DEFS_SVH
`define LC_ADDR_CODE_LEN 8'h12
`define LC_ADDR_TX_PAT 8'h13
`define LC_ADDR_UP_PAT 8'h14
`define LC_ADDR_DOWN_PAT 8'h15
`define LC_TX_SEL_MSB 7
`define LC_TX_SEL_LSB 6
`define LC_UP_LEN_MSB 5
`define LC_UP_LEN_LSB 3
`define LC_DOWN_LEN_MSB 2
`define LC_DOWN_LEN_LSB 0
`define LC_REG_RESET 8'h00
`define LC_UNMAPPED_READ 8'h00
`define LC_INTEG_MS 48
`define LC_BIT_RATE_HZ 1544000
`define LC_INTEG_BITS (`LC_INTEG_MS * `LC_BIT_RATE_HZ / 1000)
`define LC_ERR_DIV 5
`endif

/* File: lc_pkg.sv */
// Types shared by the in-band loop code block.
// Assumes nothing beyond a SystemVerilog compiler.
package lc_pkg;
	typedef logic [7:0] lc_byte_t;
	typedef logic [2:0] lc_len_t;
	typedef logic [1:0] lc_tx_sel_t;
	typedef enum {LC_TX_PASS, LC_TX_SEND} lc_tx_state_t;
endpackage

/* File: lc_det_if.sv */
// Connection between the top module and one loop code detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface lc_det_if;
	import lc_pkg::*;
	logic bit_en;
	logic bit_val;
	lc_byte_t pattern;
	lc_len_t len_sel;
	logic detected;
	modport det(input bit_en, input bit_val, input pattern, input len_sel, output detected);
	modport ctl(output bit_en, output bit_val, output pattern, output len_sel, input detected);
endinterface

/* File: lc_detector.sv */
// One repeating loop code detector with error-tolerant integration.
// Assumes receive bits arrive with a one-cycle strobe on the module's own clock.
`timescale 1ns/1ns
`include "lc_defs.svh"
module lc_detector #(
	parameter int INTEG_BITS = `LC_INTEG_BITS
) (
	input wire logic clock,
	input wire logic rst,
	lc_det_if.det port
);
	import lc_pkg::*;
	localparam int ERR_LIMIT = INTEG_BITS / `LC_ERR_DIV;

	// True when the newest n bits of h are some rotation of pattern bits 7 down to 8-n.
	function automatic logic rot_match(input lc_byte_t h, input lc_byte_t p, input int n);
		logic any;
		logic ok;
		int k;
		any = 1'b0;
		for (int r = 0; r < 8; r++) begin
			ok = (r < n);
			for (int j = 0; j < 8; j++) begin
				if (j < n && r < n) begin
					k = (j + r >= n) ? j + r - n : j + r;
					if (h[n - 1 - j] != p[7 - k])
						ok = 1'b0;
				end
			end
			any = any | ok;
		end
		return any;
	endfunction

	lc_byte_t hist;
	logic [3:0] fill;
	logic [31:0] win_cnt;
	logic [31:0] err_cnt;
	logic detected;
	lc_byte_t next_hist;
	int len;
	logic good;
	logic win_end;

	assign next_hist = {hist[6:0], port.bit_val};
	assign len = int'(port.len_sel) + 1; // R7
	// Each bit is judged on the last len bits; an error or an F bit spoils only len judgements. R9
	assign good = rot_match(next_hist, port.pattern, len) && (int'(fill) + 1 >= len);
	assign win_end = port.bit_en && (win_cnt == 32'(INTEG_BITS - 1));
	assign port.detected = detected;

	always_ff @(posedge clock) begin
		if (rst) begin
			hist <= 8'h00;
			fill <= 4'h0;
		end else if (port.bit_en) begin
			hist <= next_hist;
			if (fill != 4'h8)
				fill <= fill + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			win_cnt <= 32'h00000000;
			err_cnt <= 32'h00000000;
			detected <= 1'b0;
		end else if (port.bit_en) begin
			if (win_end) begin
				// The flag follows the most recent full window, so it drops once the code goes away. R10
				detected <= (err_cnt + 32'(!good)) <= 32'(ERR_LIMIT);
				win_cnt <= 32'h00000000;
				err_cnt <= 32'h00000000;
			end else begin
				win_cnt <= win_cnt + 32'h00000001;
				err_cnt <= err_cnt + 32'(!good);
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_flag_at_window;
		$changed(detected) |-> $past(win_end);
	endproperty
	a_flag_at_window: assert property (p_flag_at_window) else $error("Detect flag moved outside a window end."); // R10

	// A window that was still under the limit before its last bit must report the code.
	property p_clean_window_sets;
		win_end && (err_cnt < 32'(ERR_LIMIT)) |=> detected;
	endproperty
	a_clean_window_sets: assert property (p_clean_window_sets) else $error("Good window did not set the flag."); // R9

	property p_noisy_window_clears;
		win_end && (err_cnt > 32'(ERR_LIMIT)) |=> !detected;
	endproperty
	a_noisy_window_clears: assert property (p_noisy_window_clears) else $error("Bad window left the flag set."); // R10

	property p_window_length;
		win_end |=> win_cnt == 32'h00000000 && err_cnt == 32'h00000000;
	endproperty
	a_window_length: assert property (p_window_length) else $error("Integration window has the wrong length."); // R10
endmodule

/* File: lc_inband_loop.sv */
// In-band loop code generator and loop-up and loop-down detectors with their registers.
// Assumes bit strobes, payload and F-bit slot marks come from framer logic on the same clock,
// and a byte-wide register port with one-cycle write and read strobes.
// Overview of operation
// R1 - software loads pattern and transmit length
// R2 - transmit select codes 5, 6, 7, 8 bits
// R3 - pattern bit 7 sent first
// R4 - send repeats while send enable set
// R5 - F bit replaces pattern every frame
// R6 - independent loop-up and loop-down detectors
// R7 - receive length field 000..111 means 1..8
// R8 - code length register field layout
// R9 - detect framed or unframed, tolerate errors
// R10 - integrate about 48 ms before reporting
// R11 - detection sets up and down status flags
// R12 - software polls flags until code ends
// R13 - transmit pattern register at its address
// R14 - loop-up pattern register at 0x14
// R15 - loop-down pattern register at 0x15
// R16 - send bits 7 down to 8-N, repeat
`timescale 1ns/1ns
`include "lc_defs.svh"
module lc_inband_loop #(
	parameter int INTEG_BITS = `LC_INTEG_BITS
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire lc_pkg::lc_byte_t wdata,
	output lc_pkg::lc_byte_t rdata,
	input wire logic loop_code_send_en,
	input wire logic fbit_insert_dis,
	input wire logic tx_bit_en,
	input wire logic tx_fbit_slot,
	input wire logic tx_fbit,
	input wire logic tx_payload,
	output logic tx_data,
	input wire logic rx_bit_en,
	input wire logic rx_data,
	output logic loop_up_detected,
	output logic loop_down_detected
);
	import lc_pkg::*;

	lc_byte_t code_length_control;
	lc_byte_t transmit_loop_pattern;
	lc_byte_t rx_up_pattern;
	lc_byte_t rx_down_pattern;
	lc_tx_state_t tx_state;
	logic [2:0] tx_idx;
	logic [2:0] tx_last;
	lc_tx_sel_t tx_sel;
	logic pat_bit;

	lc_det_if up_if();
	lc_det_if down_if();

	// Register writes; nothing in hardware alters these, so no set and clear contention exists.
	always_ff @(posedge clock) begin
		if (rst) begin
			code_length_control <= `LC_REG_RESET;
			transmit_loop_pattern <= `LC_REG_RESET;
			rx_up_pattern <= `LC_REG_RESET;
			rx_down_pattern <= `LC_REG_RESET;
		end else if (wr_en) begin
			if (addr == `LC_ADDR_CODE_LEN) begin
				code_length_control <= wdata; // R8
			end else if (addr == `LC_ADDR_TX_PAT) begin
				transmit_loop_pattern <= wdata; // R13
			end else if (addr == `LC_ADDR_UP_PAT) begin
				rx_up_pattern <= wdata; // R14
			end else if (addr == `LC_ADDR_DOWN_PAT) begin
				rx_down_pattern <= wdata; // R15
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= `LC_UNMAPPED_READ;
		end else if (rd_en) begin
			if (addr == `LC_ADDR_CODE_LEN) begin
				rdata <= code_length_control;
			end else if (addr == `LC_ADDR_TX_PAT) begin
				rdata <= transmit_loop_pattern;
			end else if (addr == `LC_ADDR_UP_PAT) begin
				rdata <= rx_up_pattern;
			end else if (addr == `LC_ADDR_DOWN_PAT) begin
				rdata <= rx_down_pattern;
			end else begin
				rdata <= `LC_UNMAPPED_READ;
			end
		end
	end

	// Shorter codes are sent through a longer length that holds them a whole number of times,
	// so software writes a 3-bit code twice into a 6-bit span.
	assign tx_sel = code_length_control[`LC_TX_SEL_MSB:`LC_TX_SEL_LSB]; // R8
	always_comb begin
		case (tx_sel)
			2'h0: tx_last = 3'h4; // R2
			2'h1: tx_last = 3'h5; // R2
			2'h2: tx_last = 3'h6; // R2
			default: tx_last = 3'h7; // R2
		endcase
	end
	assign pat_bit = transmit_loop_pattern[3'h7 - tx_idx]; // R16

	always_ff @(posedge clock) begin
		if (rst) begin
			tx_state <= LC_TX_PASS;
		end else if (tx_bit_en) begin
			case (tx_state)
				LC_TX_PASS: if (loop_code_send_en) tx_state <= LC_TX_SEND; // R4
				LC_TX_SEND: if (!loop_code_send_en) tx_state <= LC_TX_PASS; // R4
				default: tx_state <= LC_TX_PASS;
			endcase
		end
	end

	// The index keeps running under an F bit, so the pattern phase is overwritten, not delayed.
	always_ff @(posedge clock) begin
		if (rst) begin
			tx_idx <= 3'h0;
		end else if (tx_bit_en) begin
			if (!loop_code_send_en || tx_idx >= tx_last)
				tx_idx <= 3'h0; // R3
			else
				tx_idx <= tx_idx + 3'h1; // R16
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			tx_data <= 1'b0;
		end else if (tx_bit_en) begin
			if (tx_fbit_slot && !fbit_insert_dis)
				tx_data <= tx_fbit; // R5
			else if (loop_code_send_en)
				tx_data <= pat_bit; // R4
			else
				tx_data <= tx_payload;
		end
	end

	// Both detectors see the same receive stream but keep their own pattern and length. R6
	assign up_if.bit_en = rx_bit_en;
	assign up_if.bit_val = rx_data;
	assign up_if.pattern = rx_up_pattern;
	assign up_if.len_sel = code_length_control[`LC_UP_LEN_MSB:`LC_UP_LEN_LSB]; // R7
	assign down_if.bit_en = rx_bit_en;
	assign down_if.bit_val = rx_data;
	assign down_if.pattern = rx_down_pattern;
	assign down_if.len_sel = code_length_control[`LC_DOWN_LEN_MSB:`LC_DOWN_LEN_LSB]; // R7

	lc_detector #(.INTEG_BITS(INTEG_BITS)) u_up (.clock(clock), .rst(rst), .port(up_if.det));
	lc_detector #(.INTEG_BITS(INTEG_BITS)) u_down (.clock(clock), .rst(rst), .port(down_if.det));

	always_ff @(posedge clock) begin
		if (rst) begin
			loop_up_detected <= 1'b0;
			loop_down_detected <= 1'b0;
		end else begin
			loop_up_detected <= up_if.detected; // R11
			loop_down_detected <= down_if.detected; // R11
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_write(lc_byte_t a);
		wr_en && addr == a;
	endsequence

	property p_len_write;
		s_write(`LC_ADDR_CODE_LEN) |=> code_length_control == $past(wdata);
	endproperty
	a_len_write: assert property (p_len_write) else $error("Code length register not written."); // R8

	property p_tx_pat_write;
		s_write(`LC_ADDR_TX_PAT) |=> transmit_loop_pattern == $past(wdata);
	endproperty
	a_tx_pat_write: assert property (p_tx_pat_write) else $error("Transmit pattern register not written."); // R13

	property p_up_read;
		rd_en && addr == `LC_ADDR_UP_PAT |=> rdata == $past(rx_up_pattern);
	endproperty
	a_up_read: assert property (p_up_read) else $error("Loop-up pattern read back wrong."); // R14

	property p_down_read;
		rd_en && addr == `LC_ADDR_DOWN_PAT |=> rdata == $past(rx_down_pattern);
	endproperty
	a_down_read: assert property (p_down_read) else $error("Loop-down pattern read back wrong."); // R15

	property p_fbit;
		tx_bit_en && tx_fbit_slot && !fbit_insert_dis |=> tx_data == $past(tx_fbit);
	endproperty
	a_fbit: assert property (p_fbit) else $error("F bit not inserted."); // R5

	property p_first_bit;
		tx_bit_en && loop_code_send_en && !tx_fbit_slot && tx_idx == 3'h0 |=> tx_data == $past(transmit_loop_pattern[7]);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("Pattern did not start with bit 7."); // R3

	// The state remembers that the previous strobe was not sending, so a new send must start at bit 7.
	property p_send_start;
		tx_bit_en && loop_code_send_en && tx_state == LC_TX_PASS |-> tx_idx == 3'h0;
	endproperty
	a_send_start: assert property (p_send_start) else $error("Send did not begin at the first bit."); // R3

	property p_length_wrap;
		tx_bit_en && loop_code_send_en && tx_idx == 3'h4 && tx_sel == 2'h0 |=> tx_idx == 3'h0;
	endproperty
	a_length_wrap: assert property (p_length_wrap) else $error("Five bit code did not wrap."); // R2

	property p_idle_pass;
		tx_bit_en && !loop_code_send_en && !tx_fbit_slot |=> tx_data == $past(tx_payload);
	endproperty
	a_idle_pass: assert property (p_idle_pass) else $error("Payload not passed while not sending."); // R4

	property p_flags;
		##1 loop_up_detected == $past(up_if.detected) && loop_down_detected == $past(down_if.detected);
	endproperty
	a_flags: assert property (p_flags) else $error("Status flags lag detectors wrongly."); // R11
endmodule

/* File: lc_far_end.sv */
// Far-end T1 equipment model that sends a repeating loop code into the receive bit stream.
// Assumes the block's clock and synchronous reset; one bit strobe every second cycle while run is high.
`timescale 1ns/1ns
module lc_far_end (
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire lc_pkg::lc_byte_t pattern,
	input wire logic [3:0] len,
	output logic rx_bit_en,
	output logic rx_data,
	output logic [15:0] sent
);
	import lc_pkg::*;
	logic phase;
	logic [3:0] idx;
	// Between strobes the data line toggles, so a stale bit is never taken as valid.
	// One bit in 32 is flipped to exercise the error tolerance of the detectors.
	always_ff @(posedge clock) begin
		if (rst) begin
			phase <= 1'b0;
			idx <= 4'h0;
			sent <= 16'h0000;
			rx_bit_en <= 1'b0;
			rx_data <= 1'b0;
		end else begin
			phase <= ~phase;
			rx_bit_en <= 1'b0;
			rx_data <= ~rx_data;
			if (run && phase) begin
				rx_bit_en <= 1'b1;
				rx_data <= pattern[3'(7 - idx)] ^ (sent[4:0] == 5'h1F);
				idx <= (idx >= len - 4'h1) ? 4'h0 : idx + 4'h1;
				sent <= sent + 16'h0001;
			end
		end
	end
endmodule

/* File: test_lc_inband_loop.sv */
// Self-checking bench for the in-band loop code generator and detectors.
// Assumes a 50 MHz clock and a detection window shortened to 200 received bits.
`timescale 1ns/1ns
module test_lc_inband_loop;
	import lc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	lc_byte_t wdata = 8'h00;
	lc_byte_t rdata;
	logic send_en = 1'b0;
	logic fdis = 1'b0;
	logic tbe = 1'b0;
	logic slot = 1'b0;
	logic fbit = 1'b0;
	logic payload = 1'b0;
	logic tx_data;
	logic rx_bit_en;
	logic rx_data;
	logic up_det;
	logic down_det;
	logic run = 1'b0;
	lc_byte_t far_pat = 8'h80;
	logic [3:0] far_len = 4'h5;
	logic [15:0] sent;
	int miscompares = 0;
	int compares = 0;
	lc_byte_t row_addr [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h11};
	lc_byte_t row_wr [6] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'hFF, 8'h77};
	lc_byte_t row_rd [6] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h00, 8'h00};
	lc_byte_t tx_pat = 8'hB5;
	int n;
	int sel;
	int i;
	int n_len;
	logic exp_bit;

	always #10 clock = ~clock;

	lc_inband_loop #(.INTEG_BITS(200)) lc_inband_loop_i (.clock(clock), .rst(rst), .addr(addr), .wr_en(wr_en),
		.rd_en(rd_en), .wdata(wdata), .rdata(rdata), .loop_code_send_en(send_en), .fbit_insert_dis(fdis),
		.tx_bit_en(tbe), .tx_fbit_slot(slot), .tx_fbit(fbit), .tx_payload(payload), .tx_data(tx_data),
		.rx_bit_en(rx_bit_en), .rx_data(rx_data), .loop_up_detected(up_det), .loop_down_detected(down_det));
	lc_far_end lc_far_end_i (.clock(clock), .rst(rst), .run(run), .pattern(far_pat), .len(far_len),
		.rx_bit_en(rx_bit_en), .rx_data(rx_data), .sent(sent));

	task automatic complete_run();
		if (miscompares == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp_byte(input lc_byte_t got, input lc_byte_t exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input lc_byte_t a, input lc_byte_t d);
		@(negedge clock);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clock);
		wr_en = 1'b0;
	endtask

	task automatic rd(input lc_byte_t a, input lc_byte_t e);
		@(negedge clock);
		addr = a;
		rd_en = 1'b1;
		@(negedge clock);
		rd_en = 1'b0;
		@(negedge clock);
		cmp_byte(rdata, e);
	endtask

	// Three cycles per bit, so the output is read where it is settled under either register stage.
	task automatic tx(input logic s, input logic fb, input logic pl, input logic e);
		@(negedge clock);
		tbe = 1'b1;
		slot = s;
		fbit = fb;
		payload = pl;
		@(negedge clock);
		tbe = 1'b0;
		@(negedge clock);
		cmp_bit(tx_data, e);
	endtask

	task automatic run_until(input logic [15:0] target);
		int k;
		run = 1'b1;
		for (k = 0; k < 4000 && sent !== target; k++) begin
			@(negedge clock);
		end
		run = 1'b0;
		if (sent !== target) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, sent, target);
			complete_run();
		end
		repeat (4) @(negedge clock);
	endtask

	initial begin
		repeat (5) @(negedge clock);
		rst = 1'b0;
		for (n = 0; n < 6; n++) begin
			wr(row_addr[n], row_wr[n]);
			rd(row_addr[n], row_rd[n]);
		end
		tx(1'b0, 1'b0, 1'b1, 1'b1);
		tx(1'b0, 1'b0, 1'b0, 1'b0);
		wr(8'h13, tx_pat);
		for (sel = 0; sel < 4; sel++) begin
			n_len = 5 + sel;
			wr(8'h12, {sel[1:0], 6'h00});
			send_en = 1'b0;
			tx(1'b0, 1'b0, 1'b1, 1'b1);
			send_en = 1'b1;
			for (i = 0; i < 2 * n_len + 1; i++) begin
				exp_bit = tx_pat[7 - (i % n_len)];
				fdis = (i == 6);
				if (i == 3 || i == 6) begin
					tx(1'b1, ~exp_bit, ~exp_bit, (i == 3) ? ~exp_bit : exp_bit);
				end else begin
					tx(1'b0, 1'b0, ~exp_bit, exp_bit);
				end
			end
		end
		send_en = 1'b0;
		fdis = 1'b0;
		rst = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		cmp_bit(tx_data, 1'b0);
		cmp_bit(up_det, 1'b0);
		for (n = 0; n < 4; n++) begin
			rd(lc_byte_t'(8'h12 + n), 8'h00);
		end
		wr(8'h12, 8'h22);
		wr(8'h14, 8'h84);
		wr(8'h15, 8'hC1);
		run_until(16'd600);
		cmp_bit(up_det, 1'b1);
		cmp_bit(down_det, 1'b0);
		run_until(16'd800);
		cmp_bit(up_det, 1'b1);
		far_pat = 8'hC0;
		far_len = 4'h3;
		run_until(16'd1200);
		cmp_bit(up_det, 1'b0);
		cmp_bit(down_det, 1'b1);
		complete_run();
	end
endmodule
